// File: bench/data_memory_sva.sv
// Purpose: Port checker for the data memory and table read block
// Assumes: Table pointer is not visible here, so only page bits are checked
// Notes:   Bound to the design top below
`timescale 1ns/1ps
// ************************************************************
// Checker
// ************************************************************
module data_memory_sva
	import dmem_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// Register port
	input wire logic [7:0]  addr,
	input wire logic        rd,
	input wire logic [7:0]  rdata,
	input wire logic        acc_load,
	input wire logic [7:0]  acc_in,
	input wire logic [7:0]  alu_result_register,
	// Table read
	input wire logic        last_page_table_read,
	input wire logic        current_page_table_read,
	input wire logic [3:0]  pc_page,
	input wire logic [11:0] pm_addr,
	input wire logic        pm_req,
	input wire logic        tbl_busy,
	input wire logic        tbl_done
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Steps of one table read
	sequence s_start;
		(last_page_table_read || current_page_table_read) && !tbl_busy;
	endsequence
	sequence s_fetch;
		pm_req && tbl_busy ##1 !pm_req && tbl_busy;
	endsequence

	a_last_page: assert property (
		last_page_table_read && !tbl_busy |=> pm_addr[11:8] == 4'hf)
		else $error("last page fetch off page");
	a_cur_page: assert property (
		current_page_table_read && !last_page_table_read && !tbl_busy
		|=> pm_addr[11:8] == $past(pc_page))
		else $error("current page fetch off page");
	a_two_cycles: assert property (
		s_start |=> s_fetch ##1 tbl_done && !tbl_busy)
		else $error("table read not two cycles");
	a_busy_ignore: assert property (tbl_busy |=> !pm_req)
		else $error("fetch started while busy");
	a_done_pulse: assert property (tbl_done |=> !tbl_done)
		else $error("done longer than one cycle");
	a_acc_load: assert property (
		acc_load |=> alu_result_register == $past(acc_in))
		else $error("accumulator load lost");
	a_unused_zero: assert property (
		rd && addr >= 8'h80 |=> rdata == 8'h00)
		else $error("unused address not zero");
	a_rdata_hold: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without read");
endmodule : data_memory_sva

bind data_memory_and_table_read data_memory_sva chk (.clk(clk), .rstn(rstn),
	.addr(addr), .rd(rd), .rdata(rdata), .acc_load(acc_load), .acc_in(acc_in),
	.alu_result_register(alu_result_register),
	.last_page_table_read(last_page_table_read),
	.current_page_table_read(current_page_table_read), .pc_page(pc_page),
	.pm_addr(pm_addr), .pm_req(pm_req), .tbl_busy(tbl_busy),
	.tbl_done(tbl_done));

// File: bench/tb_data_memory_and_table_read.sv
// Purpose: Directed bench for the data memory and table read block
// Assumes: Program memory word is supplied in the cycle after pm_req
// Notes:   Released program data is inverted so stale values never match
`timescale 1ns/1ps
`include "dmem_params.svh"
module tb_data_memory_and_table_read
	import dmem_pkg::*;
;
	logic        clk = 0, rstn = 0, wr = 0, rd = 0, bit_set = 0, bit_clr = 0;
	logic        acc_load = 0, lpt = 0, cpt = 0;
	logic [7:0]  addr = 0, wdata = 0, acc_in = 0, tbl_dest = 0;
	logic [7:0]  rdata, alu_result_register, pc_low_byte;
	logic [2:0]  bit_idx = 0;
	logic [3:0]  pc_page = 0;
	logic [14:0] pm_data = 0;
	logic [11:0] pm_addr;
	logic        pm_req, tbl_busy, tbl_done;
	int          n_errors = 0, n_checks = 0;
	byte_t       holes[4] = '{8'h0a, 8'h3f, 8'h80, 8'hff};

	data_memory_and_table_read uut (.clk(clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bit_set(bit_set),
		.bit_clr(bit_clr), .bit_idx(bit_idx), .acc_load(acc_load),
		.acc_in(acc_in), .last_page_table_read(lpt),
		.current_page_table_read(cpt), .tbl_dest(tbl_dest),
		.pc_page(pc_page), .pm_addr(pm_addr), .pm_req(pm_req),
		.pm_data(pm_data), .alu_result_register(alu_result_register),
		.pc_low_byte(pc_low_byte), .tbl_busy(tbl_busy), .tbl_done(tbl_done));

	// ************************************************************
	// Access tasks
	// ************************************************************
	// Free-running 200 MHz clock
	initial forever #2.5 clk = ~clk;

	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wb(input byte_t a, input byte_t d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wb

	// Read data load on the strobe edge and hold until the next read
	task rb(input byte_t a, input byte_t exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		check(16'(rdata), 16'(exp));
	endtask : rb

	task bitop(input logic s, input byte_t a, input logic [2:0] i);
		@(posedge clk);
		addr    <= a;
		bit_idx <= i;
		bit_set <= s;
		bit_clr <= !s;
		@(posedge clk);
		bit_set <= 1'b0;
		bit_clr <= 1'b0;
	endtask : bitop

	// Command stays high one extra cycle, which the busy block must ignore
	task tbl(input logic last, input logic [3:0] pg, input byte_t dst,
		input logic [14:0] w, input logic [11:0] ea);
		@(posedge clk);
		lpt      <= last;
		cpt      <= !last;
		pc_page  <= pg;
		tbl_dest <= dst;
		@(posedge clk);
		#1;
		check(16'(pm_addr), 16'(ea));
		check(16'(pm_req), 16'h0001);
		check(16'(tbl_busy), 16'h0001);
		@(posedge clk);
		lpt     <= 1'b0;
		cpt     <= 1'b0;
		pm_data <= w;
		#1;
		check(16'(pm_req), 16'h0000);
		@(posedge clk);
		pm_data <= ~w;
		#1;
		check(16'(tbl_done), 16'h0001);
		check(16'(tbl_busy), 16'h0000);
	endtask : tbl

	task conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rb(`A_PTR0, 8'h00);
		rb(`A_PTR1, 8'h00);
		wb(8'h40, 8'h5a);
		rb(8'h40, 8'h5a);
		wb(8'h7f, 8'hc3);
		rb(8'h7f, 8'hc3);
		bitop(1'b1, 8'h40, 3'd7);
		bitop(1'b0, 8'h40, 3'd1);
		rb(8'h40, 8'hd8);
		foreach (holes[i]) begin
			wb(holes[i], 8'hff);
			rb(holes[i], 8'h00);
		end
		wb(`A_TBL_HIGH, 8'h55);
		rb(`A_TBL_HIGH, 8'h00);
		wb(`A_STAT, 8'hff);
		rb(`A_STAT, 8'h00);
		wb(`A_PTR0, 8'h41);
		wb(`A_IND0, 8'ha5);
		rb(8'h41, 8'ha5);
		rb(`A_PTR0, 8'h41);
		wb(`A_BANK, 8'h01);
		wb(`A_PTR1, 8'h42);
		wb(`A_IND1, 8'h3c);
		rb(`A_IND1, 8'h3c);
		rb(8'h42, 8'h00);
		wb(`A_PTR0, 8'h42);
		rb(`A_IND0, 8'h00);
		wb(`A_PTR1, `A_IND0);
		wb(`A_IND1, 8'h77);
		rb(`A_IND1, 8'h00);
		rb(8'h42, 8'h00);
		@(posedge clk);
		acc_in   <= 8'h9e;
		acc_load <= 1'b1;
		@(posedge clk);
		acc_load <= 1'b0;
		rb(`A_ALU_RES, 8'h9e);
		check(16'(alu_result_register), 16'h009e);
		wb(`A_PC_LOW, 8'h21);
		rb(`A_PC_LOW, 8'h21);
		check(16'(pc_low_byte), 16'h0021);
		wb(`A_TBLP, 8'h06);
		tbl(1'b1, 4'h3, 8'h44, 15'h7f1a, 12'hf06);
		rb(8'h44, 8'h1a);
		rb(`A_TBL_HIGH, 8'h7f);
		wb(`A_TBLP, 8'h05);
		tbl(1'b0, 4'h3, 8'h45, 15'h0a0f, 12'h305);
		rb(8'h45, 8'h0f);
		rb(`A_TBL_HIGH, 8'h0a);
		conclude;
	end

	// Whole run is about 120 cycles; this span is ample
	initial begin
		#50000;
		n_errors++;
		conclude;
	end
endmodule : tb_data_memory_and_table_read

// File: src/data_memory_and_table_read.sv
// Purpose: Data memory, indirect ports and table reads of an 8-bit core
// Assumes: Core keeps strobes exclusive and idle while tbl_busy is high
// Notes:   Program memory answers one cycle after pm_req
//          Table high result cannot be saved and restored by software,
//          so an interrupting table read silently replaces it
//          Direct addressing always reaches bank 0; only port one banks
`timescale 1ns/1ps
`include "dmem_params.svh"

module data_memory_and_table_read
	import dmem_pkg::*;
#(
	parameter int NBANKS = 2,
	parameter int BANK_W = 1
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Register port of the core
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// Single-bit operations
	input  wire logic        bit_set,
	input  wire logic        bit_clr,
	input  wire logic [2:0]  bit_idx,
	// ALU result load
	input  wire logic        acc_load,
	input  wire logic [7:0]  acc_in,
	// Table read commands
	input  wire logic        last_page_table_read,
	input  wire logic        current_page_table_read,
	input  wire logic [7:0]  tbl_dest,
	input  wire logic [3:0]  pc_page,
	// Program memory port
	output logic      [11:0] pm_addr,
	output logic             pm_req,
	input  wire logic [14:0] pm_data,
	// Core-visible state
	output logic      [7:0]  alu_result_register,
	output logic      [7:0]  pc_low_byte,
	output logic             tbl_busy,
	output logic             tbl_done
);

	// ****************************************************************
	// State
	// ****************************************************************
	localparam int RAM_N = NBANKS * 64;

	typedef struct packed {
		logic [RAM_N-1:0][7:0] ram;
		byte_t                 pointer_zero;
		byte_t                 pointer_one;
		logic [BANK_W-1:0]     bank;
		byte_t                 alu_res;
		byte_t                 pc_low;
		byte_t                 tblp;
		byte_t                 table_high_result;
		byte_t                 rdata;
		tbl_state_t            tst;
		byte_t                 dest;
		logic [11:0]           pm_addr;
		logic                  pm_req;
		logic                  done;
		logic                  busy;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// True for either indirect port address
	function automatic logic is_port(input byte_t a);
		is_port = (a == `A_IND0) || (a == `A_IND1);
	endfunction : is_port

	// True inside the general purpose window
	function automatic logic is_gp(input byte_t a);
		is_gp = (a >= `GP_BASE) && (a < (`GP_BASE + `GP_LEN));
	endfunction : is_gp

	// Flat RAM index of a general purpose byte in a bank
	function automatic int gp_idx(input logic [BANK_W-1:0] b,
			input byte_t a);
		gp_idx = int'(b) * 64 + int'(a - `GP_BASE);
	endfunction : gp_idx

	// Read a resolved location; ports and holes answer zero
	function automatic byte_t rd_loc(input state_t s,
			input logic [BANK_W-1:0] b, input byte_t a);
		rd_loc = `RST_BYTE;
		if (is_gp(a)) begin
			rd_loc = s.ram[gp_idx(b, a)];
		end else begin
			case (a)
				`A_PTR0: rd_loc = s.pointer_zero;
				`A_PTR1: rd_loc = s.pointer_one;
				`A_BANK: rd_loc = 8'(s.bank);
				`A_ALU_RES:  rd_loc = s.alu_res;
				`A_PC_LOW:   rd_loc = s.pc_low;
				`A_TBLP:     rd_loc = s.tblp;
				`A_TBL_HIGH: rd_loc = s.table_high_result;
				// Status bit 0 mirrors the registered busy flag
				`A_STAT:     rd_loc = {7'h00, s.busy};
				default: rd_loc = `RST_BYTE;
			endcase
		end
	endfunction : rd_loc

	// Write a resolved location; read-only and holes are dropped
	function automatic state_t wr_loc(input state_t s,
			input logic [BANK_W-1:0] b, input byte_t a, input byte_t d);
		wr_loc = s;
		if (is_gp(a)) begin
			wr_loc.ram[gp_idx(b, a)] = d;
		end else begin
			case (a)
				`A_PTR0: wr_loc.pointer_zero = d;
				`A_PTR1: wr_loc.pointer_one = d;
				`A_BANK: wr_loc.bank = d[BANK_W-1:0];
				`A_ALU_RES: wr_loc.alu_res = d;
				// Lands in the register only; the core does the jump
				`A_PC_LOW:  wr_loc.pc_low = d;
				`A_TBLP: wr_loc.tblp = d;
				// Table high, status and holes are protected
				default: wr_loc = s;
			endcase
		end
	endfunction : wr_loc

	// ****************************************************************
	// Address resolution through the indirect ports
	// ****************************************************************
	// Port zero is pinned to bank 0; port one follows the bank register
	function automatic void resolve(input state_t s, input byte_t a,
			output logic [BANK_W-1:0] b, output byte_t ea,
			output logic dead);
		b    = '0;
		ea   = a;
		dead = 1'b0;
		// A pointer naming a port would recurse; such an access is dropped
		// instead, which also keeps the path through here one level deep
		if (a == `A_IND0) begin
			ea   = s.pointer_zero;
			b    = '0;
			dead = is_port(s.pointer_zero);
		end else if (a == `A_IND1) begin
			ea   = s.pointer_one;
			b    = s.bank;
			dead = is_port(s.pointer_one);
		end
	endfunction : resolve

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Resolved bus address, shared by read, write and bit operations
	logic [BANK_W-1:0] bus_bank;
	byte_t             bus_ea;
	logic              bus_dead;
	byte_t             bus_old;
	byte_t             bit_mask;

	always_comb begin
		resolve(st_reg, addr, bus_bank, bus_ea, bus_dead);
		bus_old  = bus_dead ? `RST_BYTE
			: rd_loc(st_reg, bus_bank, bus_ea);
		bit_mask = 8'h01 << bit_idx;
	end

	// Table destination is resolved the same way as a bus write
	logic [BANK_W-1:0] dst_bank;
	byte_t             dst_ea;
	logic              dst_dead;

	always_comb begin
		resolve(st_reg, st_reg.dest, dst_bank, dst_ea, dst_dead);
	end

	always_comb begin
		st_next        = st_reg;
		st_next.done   = 1'b0;
		st_next.pm_req = 1'b0;

		// Read data load on the strobe and hold until the next read
		if (rd) begin
			st_next.rdata = bus_old;
		end

		// Plain store of a value routed from the accumulator; the bus
		// has no register-to-register move, so copies cost two strobes
		if (wr && !bus_dead) begin
			st_next = wr_loc(st_next, bus_bank, bus_ea, wdata);
		end

		// Read-modify-write of one bit of the addressed byte
		if ((bit_set || bit_clr) && !bus_dead) begin
			st_next = wr_loc(st_next, bus_bank, bus_ea,
				bit_set ? (bus_old | bit_mask)
				: (bus_old & ~bit_mask));
		end

		// ALU result lands only in the accumulator
		if (acc_load) begin
			st_next.alu_res = acc_in;
		end

		// Table read sequencer: issue, wait for ROM, then load
		case (st_reg.tst)
			TBL_IDLE: begin
				if (last_page_table_read) begin
					st_next.pm_addr = {`LAST_PAGE, st_reg.tblp};
					st_next.pm_req  = 1'b1;
					st_next.busy    = 1'b1;
					st_next.dest    = tbl_dest;
					st_next.tst     = TBL_FETCH;
				end else if (current_page_table_read) begin
					st_next.pm_addr = {pc_page, st_reg.tblp};
					st_next.pm_req  = 1'b1;
					st_next.busy    = 1'b1;
					st_next.dest    = tbl_dest;
					st_next.tst     = TBL_FETCH;
				end
			end
			TBL_FETCH: begin
				// ROM samples the address on this edge; commands seen here
				// or in the load step are dropped, not queued
				st_next.tst = TBL_LOAD;
			end
			TBL_LOAD: begin
				// Load wins over a same-cycle bus write to the same place
				st_next.table_high_result =
					{1'b0, pm_data[14:8]};
				if (!dst_dead) begin
					st_next = wr_loc(st_next, dst_bank, dst_ea,
						pm_data[7:0]);
				end
				st_next.done = 1'b1;
				st_next.busy = 1'b0;
				st_next.tst  = TBL_IDLE;
			end
			default: begin
				st_next.busy = 1'b0;
				st_next.tst = TBL_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Whole RAM clears at reset so unused reads are defined from start
	// Costs a wide reset fan-out; the trade buys repeatable reads
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg                   <= '0;
			st_reg.bank              <= BANK_W'(`RST_BANK);
			st_reg.alu_res           <= `RST_BYTE;
			st_reg.pc_low            <= `RST_BYTE;
			st_reg.busy              <= 1'b0;
			st_reg.table_high_result <= `RST_BYTE;
			st_reg.tst               <= TBL_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Outputs, all straight from the state register
	// ****************************************************************
	assign rdata               = st_reg.rdata;
	assign pm_addr             = st_reg.pm_addr;
	assign pm_req              = st_reg.pm_req;
	assign alu_result_register = st_reg.alu_res;
	assign pc_low_byte         = st_reg.pc_low;
	// Busy is its own flop so the pin carries no decode glitches
	assign tbl_busy            = st_reg.busy;
	assign tbl_done            = st_reg.done;

endmodule : data_memory_and_table_read

// File: src/dmem_params.svh
// Purpose: Addresses, reset values and timing counts of the data memory
// Assumes: Included by the data memory core and its bench
// Notes:   Definitions only
`ifndef DMEM_PARAMS_SVH
`define DMEM_PARAMS_SVH
// Special-function addresses, same in every bank
`define A_IND0     8'h00
`define A_PTR0     8'h01
`define A_IND1     8'h02
`define A_PTR1     8'h03
`define A_BANK     8'h04
`define A_ALU_RES  8'h05
`define A_PC_LOW   8'h06
`define A_TBLP     8'h07
`define A_TBL_HIGH 8'h08
`define A_STAT     8'h09
// General purpose window, per bank
`define GP_BASE    8'h40
`define GP_LEN     8'h40
// Table reads
`define LAST_PAGE  4'hf
`define TBL_CYCLES 2
// Reset values
`define RST_BYTE   8'h00
`define RST_BANK   1'b0
`endif

// File: src/dmem_pkg.sv
// Purpose: Types shared by the data memory core and its bench
// Assumes: Nothing
// Notes:   Constants live in dmem_params.svh
package dmem_pkg;
	// Table read sequencer
	typedef enum logic [1:0] {
		TBL_IDLE,
		TBL_FETCH,
		TBL_LOAD
	} tbl_state_t;
	typedef logic [7:0] byte_t;
endpackage : dmem_pkg
